// ===== verilog/ssc_sys_ctrl.sv
// system control register low bits for a two-socket card bridge
//
// Behaviour
// - power stream busy bit 11 holds from request until stream and delay end
// - power up wait bit 10 set after up stream, cleared after up delay
// - power down wait bit 9 set after down stream, cleared after down delay
// - per-socket probe active bit 8 follows interrogation, resets to zero
// - bit 7 always reads zero
// - bit 6 set gates card machine clock when card present, idle, clock stopped
// - id lock bit 5, reset one, makes identity registers read-only
// - card parity errors raise serr only while bit 4 is one
// - bit 1 set blocks clock stopping by both clock-run protocols
// - bit 0 clear shares ring indicate and wake event on one terminal
// - shared terminal with both enabled carries ring indicate only
// - bit 0 set puts only wake event on the terminal
// - global bits are one copy reached only through function 0
`timescale 1ns/1ps
module ssc_sys_ctrl #(
    parameter int UP_CYCLES   = ssc_pkg::PWR_UP_CYCLES,
    parameter int DOWN_CYCLES = ssc_pkg::PWR_DOWN_CYCLES
) (
    // clock and reset
    input  wire logic                               clk_i,
    input  wire logic                               arst_n_i,
    // configuration access to this register
    input  wire logic                               cfg_wr_i,
    input  wire logic                               cfg_rd_i,
    input  wire logic                               cfg_func_i,
    input  wire logic [1:0]                         cfg_be_i,
    input  wire logic [ssc_pkg::DATA_W-1:0]         cfg_wdata_i,
    output logic [ssc_pkg::DATA_W-1:0]              cfg_rdata_o,
    output logic                                    cfg_rvalid_o,
    // power switch serializer events
    input  wire logic                               pwr_req_i,
    input  wire logic                               pwr_up_i,
    input  wire logic                               stream_done_i,
    // per-socket card state
    input  wire logic [ssc_pkg::NUM_SOCKETS-1:0]    probe_start_i,
    input  wire logic [ssc_pkg::NUM_SOCKETS-1:0]    probe_done_i,
    input  wire logic [ssc_pkg::NUM_SOCKETS-1:0]    card_present_i,
    input  wire logic [ssc_pkg::NUM_SOCKETS-1:0]    card_idle_i,
    input  wire logic [ssc_pkg::NUM_SOCKETS-1:0]    card_clk_stopped_i,
    input  wire logic [ssc_pkg::NUM_SOCKETS-1:0]    card_parity_err_i,
    input  wire logic [ssc_pkg::NUM_SOCKETS-1:0]    ring_indicate_i,
    input  wire logic [ssc_pkg::NUM_SOCKETS-1:0]    ring_en_i,
    input  wire logic [ssc_pkg::NUM_SOCKETS-1:0]    pme_i,
    input  wire logic [ssc_pkg::NUM_SOCKETS-1:0]    pme_en_i,
    // control outputs
    output logic [ssc_pkg::NUM_SOCKETS-1:0]         card_sm_clk_en_o,
    output logic [ssc_pkg::NUM_SOCKETS-1:0]         wake_pin_o,
    output logic                                    id_regs_wr_en_o,
    output logic                                    serr_req_o,
    output logic                                    clock_stop_inhibit_o,
    // status flags
    output logic                                    power_stream_busy_o,
    output logic                                    power_up_wait_o,
    output logic                                    power_down_wait_o,
    output logic [ssc_pkg::NUM_SOCKETS-1:0]         card_probe_active_o
);

    // global control bits, one copy
    logic                               id_lock;
    logic                               card_parity_report_en;
    logic                               clock_stop_inhibit;
    logic                               next_id_lock;
    logic                               next_card_parity_report_en;
    logic                               next_clock_stop_inhibit;
    // per-function control bits
    logic [ssc_pkg::NUM_SOCKETS-1:0]    idle_clock_gating_en;
    logic [ssc_pkg::NUM_SOCKETS-1:0]    rsvd_rw3;
    logic [ssc_pkg::NUM_SOCKETS-1:0]    wake_pin_share_sel;
    logic [ssc_pkg::NUM_SOCKETS-1:0]    next_idle_clock_gating_en;
    logic [ssc_pkg::NUM_SOCKETS-1:0]    next_rsvd_rw3;
    logic [ssc_pkg::NUM_SOCKETS-1:0]    next_wake_pin_share_sel;
    logic [ssc_pkg::NUM_SOCKETS-1:0]    next_probe;
    logic [ssc_pkg::NUM_SOCKETS-1:0]    next_clk_en;
    logic [ssc_pkg::NUM_SOCKETS-1:0]    next_wake;
    logic [ssc_pkg::DATA_W-1:0]         next_rdata;
    logic                               wr_lo;
    logic                               wr_global;

    // global copy is only reachable from function 0
    function automatic logic is_global_func(input logic func);
        return func == ssc_pkg::GLOBAL_FUNC;
    endfunction

    // ------------------------------------------------------------
    // power stream tracker
    // ------------------------------------------------------------
    ssc_power_seq #(
        .UP_CYCLES   (UP_CYCLES),
        .DOWN_CYCLES (DOWN_CYCLES)
    ) u_power_seq (
        .clk_i               (clk_i),
        .arst_n_i            (arst_n_i),
        .pwr_req_i           (pwr_req_i),
        .pwr_up_i            (pwr_up_i),
        .stream_done_i       (stream_done_i),
        .power_stream_busy_o (power_stream_busy_o),
        .power_up_wait_o     (power_up_wait_o),
        .power_down_wait_o   (power_down_wait_o)
    );

    // ------------------------------------------------------------
    // writable bits; only byte lane 0 holds any of them
    // ------------------------------------------------------------
    assign wr_lo     = cfg_wr_i & cfg_be_i[0];
    assign wr_global = wr_lo & is_global_func(cfg_func_i);

    always_comb begin
        next_id_lock               = id_lock;
        next_card_parity_report_en = card_parity_report_en;
        next_clock_stop_inhibit    = clock_stop_inhibit;
        if (wr_global) begin
            next_id_lock               = cfg_wdata_i[ssc_pkg::BIT_ID_LOCK];
            next_card_parity_report_en = cfg_wdata_i[ssc_pkg::BIT_PARITY_REPORT];
            next_clock_stop_inhibit    = cfg_wdata_i[ssc_pkg::BIT_CLK_STOP_INH];
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            id_lock               <= ssc_pkg::RST_ID_LOCK;
            card_parity_report_en <= ssc_pkg::RST_PARITY_REPORT;
            clock_stop_inhibit    <= ssc_pkg::RST_CLK_STOP_INH;
        end else begin
            id_lock               <= next_id_lock;
            card_parity_report_en <= next_card_parity_report_en;
            clock_stop_inhibit    <= next_clock_stop_inhibit;
        end
    end

    // ------------------------------------------------------------
    // per-socket bits and socket-side outputs
    // ------------------------------------------------------------
    for (genvar s = 0; s < ssc_pkg::NUM_SOCKETS; s++) begin : g_sock
        logic sel_wr;
        assign sel_wr = wr_lo & (cfg_func_i == 1'(s));

        always_comb begin
            next_idle_clock_gating_en[s] = idle_clock_gating_en[s];
            // reserved bit simply stored; software keeps its reset value
            next_rsvd_rw3[s]             = rsvd_rw3[s];
            next_wake_pin_share_sel[s]   = wake_pin_share_sel[s];
            if (sel_wr) begin
                next_idle_clock_gating_en[s] = cfg_wdata_i[ssc_pkg::BIT_IDLE_GATING];
                next_rsvd_rw3[s]             = cfg_wdata_i[ssc_pkg::BIT_RSVD_RW3];
                next_wake_pin_share_sel[s]   = cfg_wdata_i[ssc_pkg::BIT_WAKE_SHARE_SEL];
            end
            // probe flag, start wins over done
            next_probe[s] = probe_start_i[s] | (card_probe_active_o[s] & ~probe_done_i[s]);
            next_clk_en[s] = ~(idle_clock_gating_en[s] & card_present_i[s]
                               & card_idle_i[s] & card_clk_stopped_i[s]);
            // ring indicate wins when both enabled and bit 0 is clear
            if (wake_pin_share_sel[s]) begin
                next_wake[s] = pme_en_i[s] & pme_i[s];
            end else if (ring_en_i[s]) begin
                next_wake[s] = ring_indicate_i[s];
            end else begin
                next_wake[s] = pme_en_i[s] & pme_i[s];
            end
        end

        always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                idle_clock_gating_en[s] <= ssc_pkg::RST_IDLE_GATING;
                rsvd_rw3[s]             <= ssc_pkg::RST_RSVD_RW3;
                wake_pin_share_sel[s]   <= ssc_pkg::RST_WAKE_SHARE_SEL;
                card_probe_active_o[s]  <= 1'b0;
                card_sm_clk_en_o[s]     <= 1'b1;
                wake_pin_o[s]           <= 1'b0;
            end else begin
                idle_clock_gating_en[s] <= next_idle_clock_gating_en[s];
                rsvd_rw3[s]             <= next_rsvd_rw3[s];
                wake_pin_o[s]           <= next_wake[s];
                wake_pin_share_sel[s]   <= next_wake_pin_share_sel[s];
                card_probe_active_o[s]  <= next_probe[s];
                card_sm_clk_en_o[s]     <= next_clk_en[s];
            end
        end
    end

    // ------------------------------------------------------------
    // read path: answer one cycle after the strobe
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = '0;
        next_rdata[ssc_pkg::BIT_RSVD_RO7]       = 1'b0;
        next_rdata[ssc_pkg::BIT_PROBE_ACTIVE]   = card_probe_active_o[cfg_func_i];
        next_rdata[ssc_pkg::BIT_IDLE_GATING]    = idle_clock_gating_en[cfg_func_i];
        next_rdata[ssc_pkg::BIT_RSVD_RW3]       = rsvd_rw3[cfg_func_i];
        next_rdata[ssc_pkg::BIT_WAKE_SHARE_SEL] = wake_pin_share_sel[cfg_func_i];
        // global bits read zero from function 1
        if (is_global_func(cfg_func_i)) begin
            next_rdata[ssc_pkg::BIT_PWR_STREAM]    = power_stream_busy_o;
            next_rdata[ssc_pkg::BIT_PWR_UP_WAIT]   = power_up_wait_o;
            next_rdata[ssc_pkg::BIT_PWR_DOWN_WAIT] = power_down_wait_o;
            next_rdata[ssc_pkg::BIT_ID_LOCK]       = id_lock;
            next_rdata[ssc_pkg::BIT_PARITY_REPORT] = card_parity_report_en;
            next_rdata[ssc_pkg::BIT_CLK_STOP_INH]  = clock_stop_inhibit;
        end
    end

    // ------------------------------------------------------------
    // registered control outputs and read answer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_rdata_o          <= '0;
            cfg_rvalid_o         <= 1'b0;
            id_regs_wr_en_o      <= 1'b0;
            serr_req_o           <= 1'b0;
            clock_stop_inhibit_o <= 1'b0;
        end else begin
            cfg_rdata_o          <= cfg_rd_i ? next_rdata : '0;
            cfg_rvalid_o         <= cfg_rd_i;
            id_regs_wr_en_o      <= ~id_lock;
            serr_req_o           <= card_parity_report_en & (|card_parity_err_i);
            clock_stop_inhibit_o <= clock_stop_inhibit;
        end
    end

endmodule

// ===== verilog/ssc_pkg.sv
// package of constants for the socket system control low bits
package ssc_pkg;

    // ------------------------------------------------------------
    // sockets and access
    // ------------------------------------------------------------
    localparam int          NUM_SOCKETS        = 2;
    localparam int          DATA_W             = 32;
    localparam logic [0:0]  GLOBAL_FUNC        = 1'h0;

    // ------------------------------------------------------------
    // bit positions inside the system control register
    // ------------------------------------------------------------
    localparam int          BIT_WAKE_SHARE_SEL = 0;
    localparam int          BIT_CLK_STOP_INH   = 1;
    localparam int          BIT_RSVD_RW3       = 3;
    localparam int          BIT_PARITY_REPORT  = 4;
    localparam int          BIT_ID_LOCK        = 5;
    localparam int          BIT_IDLE_GATING    = 6;
    localparam int          BIT_RSVD_RO7       = 7;
    localparam int          BIT_PROBE_ACTIVE   = 8;
    localparam int          BIT_PWR_DOWN_WAIT  = 9;
    localparam int          BIT_PWR_UP_WAIT    = 10;
    localparam int          BIT_PWR_STREAM     = 11;

    // ------------------------------------------------------------
    // reset values of the writable bits
    // ------------------------------------------------------------
    localparam logic        RST_WAKE_SHARE_SEL = 1'h0;
    localparam logic        RST_CLK_STOP_INH   = 1'h0;
    localparam logic        RST_RSVD_RW3       = 1'h0;
    localparam logic        RST_PARITY_REPORT  = 1'h0;
    localparam logic        RST_ID_LOCK        = 1'h1;
    localparam logic        RST_IDLE_GATING    = 1'h0;

    // ------------------------------------------------------------
    // timing: settling delays after a power stream
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS      = 10;
    localparam int          PWR_UP_DELAY_US    = 100;
    localparam int          PWR_DOWN_DELAY_US  = 50;
    localparam int          PWR_UP_CYCLES      = (PWR_UP_DELAY_US * 1000) / CLK_PERIOD_NS;
    localparam int          PWR_DOWN_CYCLES    = (PWR_DOWN_DELAY_US * 1000) / CLK_PERIOD_NS;
    localparam int          DELAY_CNT_W        = 24;

    // ------------------------------------------------------------
    // power sequence states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PS_IDLE,
        PS_STREAM,
        PS_WAIT_UP,
        PS_WAIT_DOWN
    } ssc_pwr_state_t;

endpackage

// ===== verilog/ssc_power_seq.sv
// power stream progress and settling delay tracker
`timescale 1ns/1ps
module ssc_power_seq #(
    parameter int UP_CYCLES   = ssc_pkg::PWR_UP_CYCLES,
    parameter int DOWN_CYCLES = ssc_pkg::PWR_DOWN_CYCLES
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    // serializer events
    input  wire logic pwr_req_i,
    input  wire logic pwr_up_i,
    input  wire logic stream_done_i,
    // status flags
    output logic      power_stream_busy_o,
    output logic      power_up_wait_o,
    output logic      power_down_wait_o
);

    ssc_pkg::ssc_pwr_state_t              state;
    ssc_pkg::ssc_pwr_state_t              next_state;
    logic [ssc_pkg::DELAY_CNT_W-1:0]      cnt;
    logic [ssc_pkg::DELAY_CNT_W-1:0]      next_cnt;
    logic                                 dir_up;
    logic                                 next_dir_up;

    // ------------------------------------------------------------
    // sequence: stream, then settle, then idle
    // ------------------------------------------------------------
    always_comb begin
        next_state  = state;
        next_cnt    = cnt;
        next_dir_up = dir_up;
        case (state)
            ssc_pkg::PS_IDLE: begin
                if (pwr_req_i) begin
                    next_state  = ssc_pkg::PS_STREAM;
                    next_dir_up = pwr_up_i;
                end
            end
            ssc_pkg::PS_STREAM: begin
                // a new request mid-stream is taken by the serializer, not here
                if (stream_done_i) begin
                    if (dir_up) begin
                        next_state = ssc_pkg::PS_WAIT_UP;
                        next_cnt   = ssc_pkg::DELAY_CNT_W'(UP_CYCLES - 1);
                    end else begin
                        next_state = ssc_pkg::PS_WAIT_DOWN;
                        next_cnt   = ssc_pkg::DELAY_CNT_W'(DOWN_CYCLES - 1);
                    end
                end
            end
            ssc_pkg::PS_WAIT_UP, ssc_pkg::PS_WAIT_DOWN: begin
                if (cnt == '0) begin
                    next_state = ssc_pkg::PS_IDLE;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            default: begin
                next_state = ssc_pkg::PS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state  <= ssc_pkg::PS_IDLE;
            cnt    <= '0;
            dir_up <= 1'b0;
        end else begin
            state  <= next_state;
            cnt    <= next_cnt;
            dir_up <= next_dir_up;
        end
    end

    // ------------------------------------------------------------
    // flags registered from the next state so they track it exactly
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            power_stream_busy_o <= 1'b0;
            power_up_wait_o     <= 1'b0;
            power_down_wait_o   <= 1'b0;
        end else begin
            power_stream_busy_o <= (next_state != ssc_pkg::PS_IDLE);
            power_up_wait_o     <= (next_state == ssc_pkg::PS_WAIT_UP);
            power_down_wait_o   <= (next_state == ssc_pkg::PS_WAIT_DOWN);
        end
    end

endmodule

// ===== sim/ssc_sys_ctrl_checker.sv
// assertion checker for the system control low bits
`timescale 1ns/1ps
module ssc_sys_ctrl_checker #(
    parameter int UP_CYCLES   = 3,
    parameter int DOWN_CYCLES = 2
) (
    // clock, reset and read port
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        cfg_rd_i,
    input  wire logic [31:0] cfg_rdata_o,
    input  wire logic        cfg_rvalid_o,
    // events and flags
    input  wire logic        pwr_req_i,
    input  wire logic        stream_done_i,
    input  wire logic [1:0]  probe_start_i,
    input  wire logic [1:0]  probe_done_i,
    input  wire logic [1:0]  card_parity_err_i,
    input  wire logic        serr_req_o,
    input  wire logic        power_stream_busy_o,
    input  wire logic        power_up_wait_o,
    input  wire logic        power_down_wait_o,
    input  wire logic [1:0]  card_probe_active_o
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    property p_busy_rise; $rose(power_stream_busy_o) |-> $past(pwr_req_i); endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy rose without request");
    property p_busy_fall;
        $fell(power_stream_busy_o) |-> $fell(power_up_wait_o) || $fell(power_down_wait_o);
    endproperty
    a_busy_fall: assert property (p_busy_fall) else $error("busy dropped before delay end");
    property p_up_len; $rose(power_up_wait_o) |-> ##UP_CYCLES $fell(power_up_wait_o); endproperty
    a_up_len: assert property (p_up_len) else $error("up wait length wrong");
    property p_up_cause; $rose(power_up_wait_o) |-> $past(stream_done_i) && power_stream_busy_o; endproperty
    a_up_cause: assert property (p_up_cause) else $error("up wait without stream end");
    property p_down_len; $rose(power_down_wait_o) |-> ##DOWN_CYCLES $fell(power_down_wait_o); endproperty
    a_down_len: assert property (p_down_len) else $error("down wait length wrong");
    // a wait flag always sits inside a busy stretch, never both at once
    property p_wait_busy;
        (power_up_wait_o || power_down_wait_o) |-> power_stream_busy_o && !(power_up_wait_o && power_down_wait_o);
    endproperty
    a_wait_busy: assert property (p_wait_busy) else $error("wait flags inconsistent");
    property p_probe_set; probe_start_i[1] |=> card_probe_active_o[1]; endproperty
    a_probe_set: assert property (p_probe_set) else $error("probe flag not set");
    property p_probe_clr; probe_done_i[0] && !probe_start_i[0] |=> !card_probe_active_o[0]; endproperty
    a_probe_clr: assert property (p_probe_clr) else $error("probe flag not cleared");
    property p_serr_cause; serr_req_o |-> $past(card_parity_err_i) != 2'h0; endproperty
    a_serr_cause: assert property (p_serr_cause) else $error("serr without parity error");
    property p_rd_ans; cfg_rd_i |=> cfg_rvalid_o && cfg_rdata_o[7] == 1'h0 && cfg_rdata_o[31:12] == 20'h0; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer wrong");

    // main scenarios reached
    c_up: cover property ($rose(power_up_wait_o));
    c_down: cover property ($rose(power_down_wait_o));
    c_serr: cover property (serr_req_o);
endmodule

bind ssc_sys_ctrl ssc_sys_ctrl_checker #(.UP_CYCLES(UP_CYCLES), .DOWN_CYCLES(DOWN_CYCLES))
    ssc_sys_ctrl_checker_inst (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .cfg_rd_i(cfg_rd_i), .cfg_rdata_o(cfg_rdata_o),
    .cfg_rvalid_o(cfg_rvalid_o), .pwr_req_i(pwr_req_i), .stream_done_i(stream_done_i),
    .probe_start_i(probe_start_i), .probe_done_i(probe_done_i), .card_parity_err_i(card_parity_err_i),
    .serr_req_o(serr_req_o), .power_stream_busy_o(power_stream_busy_o), .power_up_wait_o(power_up_wait_o),
    .power_down_wait_o(power_down_wait_o), .card_probe_active_o(card_probe_active_o)
);

// ===== sim/ssc_sys_ctrl_tb_top.sv
// self-checking bench for the system control low bits
`timescale 1ns/1ps
module ssc_sys_ctrl_tb_top;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic        clk_i = 1'h0, arst_n_i = 1'h0, cfg_wr_i = 1'h0, cfg_rd_i = 1'h0, cfg_func_i = 1'h0;
    logic        pwr_req_i = 1'h0, pwr_up_i = 1'h0, stream_done_i = 1'h0;
    logic [1:0]  cfg_be_i = 2'h0, probe_start_i = 2'h0, probe_done_i = 2'h0, card_parity_err_i = 2'h0;
    logic [1:0]  card_present_i = 2'h3, card_idle_i = 2'h3, card_clk_stopped_i = 2'h3;
    logic [31:0] cfg_wdata_i = 32'h0;
    logic [3:0]  wake_in = 4'h0; // ring, ring enable, wake, wake enable
    logic [31:0] cfg_rdata_o;
    logic [1:0]  card_sm_clk_en_o, wake_pin_o, card_probe_active_o;
    logic        cfg_rvalid_o, id_regs_wr_en_o, serr_req_o, clock_stop_inhibit_o;
    logic        power_stream_busy_o, power_up_wait_o, power_down_wait_o;
    int          n_fail = 0;
    int          compares = 0;

    always #5 clk_i = ~clk_i;

    // short settling counts keep the power walks brief
    ssc_sys_ctrl #(.UP_CYCLES(3), .DOWN_CYCLES(2)) ssc_sys_ctrl_inst (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_func_i(cfg_func_i),
        .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
        .pwr_req_i(pwr_req_i), .pwr_up_i(pwr_up_i), .stream_done_i(stream_done_i),
        .probe_start_i(probe_start_i), .probe_done_i(probe_done_i), .card_present_i(card_present_i),
        .card_idle_i(card_idle_i), .card_clk_stopped_i(card_clk_stopped_i), .card_parity_err_i(card_parity_err_i),
        .ring_indicate_i({2{wake_in[3]}}), .ring_en_i({2{wake_in[2]}}), .pme_i({2{wake_in[1]}}),
        .pme_en_i({2{wake_in[0]}}), .card_sm_clk_en_o(card_sm_clk_en_o), .wake_pin_o(wake_pin_o),
        .id_regs_wr_en_o(id_regs_wr_en_o), .serr_req_o(serr_req_o), .clock_stop_inhibit_o(clock_stop_inhibit_o),
        .power_stream_busy_o(power_stream_busy_o), .power_up_wait_o(power_up_wait_o),
        .power_down_wait_o(power_down_wait_o), .card_probe_active_o(card_probe_active_o)
    );

    // ------------------------------------------------------------
    // access and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // inputs move 1 ns after the edge so the design samples settled values
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic f, input logic [1:0] be, input logic [31:0] d);
        cfg_func_i = f;
        cfg_be_i = be;
        cfg_wdata_i = d;
        cfg_wr_i = 1'h1;
        cyc(1);
        cfg_wr_i = 1'h0;
        // let an edge pass so a following strobe never toggles in the same step
        cyc(1);
    endtask
    task automatic rd(input logic f, input logic [31:0] exp);
        cfg_func_i = f;
        cfg_rd_i = 1'h1;
        cyc(1);
        cfg_rd_i = 1'h0;
        chk("rvalid", cfg_rvalid_o, 32'h1);
        chk("rdata", cfg_rdata_o, exp);
        cyc(1);
    endtask
    // parity error with a given report setting, serr watched over two cycles
    task automatic parity(input logic [31:0] ctl, input logic exp);
        logic seen;
        seen = 1'h0;
        wr(1'h0, 2'h3, ctl);
        card_parity_err_i = 2'h1;
        repeat (2) begin
            cyc(1);
            card_parity_err_i = 2'h0;
            seen = seen | serr_req_o;
        end
        chk("serr", seen, exp);
    endtask
    function automatic logic wake_exp(input logic sel);
        return (sel || !wake_in[2]) ? (wake_in[1] & wake_in[0]) : wake_in[3];
    endfunction
    task automatic tally_and_finish();
        if (n_fail == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        cyc(6);
        arst_n_i = 1'h1;
        rd(1'h0, 32'h20);
        rd(1'h1, 32'h0);
        chk("id_wr", id_regs_wr_en_o, 32'h0);
        wr(1'h0, 2'h3, 32'hFFFFFFF7);
        // function 1 tries to clear the global bits; they must survive
        wr(1'h1, 2'h3, 32'hFFFFFFC1);
        rd(1'h0, 32'h73);
        rd(1'h1, 32'h41);
        chk("clk_inh", clock_stop_inhibit_o, 32'h1);
        parity(32'h10, 1'h1);
        wr(1'h0, 2'h0, 32'h22);
        rd(1'h0, 32'h10);
        wr(1'h0, 2'h3, 32'h0);
        rd(1'h0, 32'h0);
        rd(1'h1, 32'h41);
        cyc(1);
        chk("id_wr", id_regs_wr_en_o, 32'h1);
        chk("clk_inh", clock_stop_inhibit_o, 32'h0);
        chk("clk_en", card_sm_clk_en_o, 32'h1);
        card_present_i = 2'h1;
        cyc(2);
        chk("clk_en", card_sm_clk_en_o, 32'h3);
        card_present_i = 2'h3;
        card_idle_i = 2'h1;
        cyc(2);
        chk("clk_en", card_sm_clk_en_o, 32'h3);
        parity(32'h0, 1'h0);
        // socket 0 shares the terminal, socket 1 carries the wake event only
        for (int i = 0; i < 16; i++) begin
            wake_in = i[3:0];
            cyc(2);
            chk("wake", wake_pin_o, {wake_exp(1'h1), wake_exp(1'h0)});
        end
        pwr_req_i = 1'h1;
        pwr_up_i = 1'h1;
        cyc(1);
        chk("busy", power_stream_busy_o, 32'h1);
        pwr_up_i = 1'h0;
        cyc(1);
        pwr_req_i = 1'h0;
        stream_done_i = 1'h1;
        cyc(1);
        stream_done_i = 1'h0;
        chk("up_wait", power_up_wait_o, 32'h1);
        rd(1'h0, 32'hC00);
        chk("up_wait", power_up_wait_o, 32'h1);
        cyc(1);
        chk("flags", {power_stream_busy_o, power_up_wait_o}, 32'h0);
        rd(1'h1, 32'h41);
        pwr_req_i = 1'h1;
        cyc(1);
        pwr_req_i = 1'h0;
        stream_done_i = 1'h1;
        cyc(1);
        stream_done_i = 1'h0;
        chk("down_wait", power_down_wait_o, 32'h1);
        rd(1'h0, 32'hA00);
        chk("flags", {power_stream_busy_o, power_down_wait_o}, 32'h0);
        probe_start_i = 2'h3;
        cyc(1);
        probe_start_i = 2'h0;
        rd(1'h1, 32'h141);
        probe_done_i = 2'h1;
        cyc(1);
        probe_done_i = 2'h0;
        chk("probe", card_probe_active_o, 32'h2);
        arst_n_i = 1'h0;
        cyc(2);
        arst_n_i = 1'h1;
        chk("probe", card_probe_active_o, 32'h0);
        rd(1'h0, 32'h20);
        tally_and_finish();
    end

    // cut a hang short well beyond the expected run of under a hundred cycles
    initial begin
        #100000;
        n_fail++;
        tally_and_finish();
    end
endmodule
